//--- rtl/spmd_defines.svh
// register map, field values and timing counts of the panel monitor
// assumes inclusion by bare name from the panel design file
`ifndef SPMD_DEFINES_SVH
`define SPMD_DEFINES_SVH

// ==========================================================
// register word addresses
`define SPMD_A_MONSEL 8'h00
`define SPMD_A_SPECFN 8'h01
`define SPMD_A_FMASK 8'h02
`define SPMD_A_MAPT1 8'h03
`define SPMD_A_MAPT3 8'h05
`define SPMD_A_MVC1 8'h06
`define SPMD_A_MVC4 8'h09
`define SPMD_A_JOGSPD 8'h0a
`define SPMD_A_STATUS 8'h0b
`define SPMD_A_DISP 8'h0c

// ==========================================================
// reset values and special-function values
`define SPMD_MONSEL_RST 5'h00
`define SPMD_JOG_RST 16'h0014
`define SPMD_FN_FORCE 16'h0196
`define SPMD_FN_NORMAL 16'h0190
`define SPMD_Z_STEP 32'h00001388

// ==========================================================
// monitor codes
`define SPMD_CODE_MAX 5'h1a
`define SPMD_CODE_INERTIA 5'h0f
`define SPMD_CODE_RESON 5'h11
`define SPMD_CODE_ZABS 5'h12
`define SPMD_CODE_MAP1 5'h13
`define SPMD_CODE_MAP3 5'h15
`define SPMD_CODE_MV1 5'h17

// ==========================================================
// parameter-mode selections
`define SPMD_PSEL_FLAST 4'h4
`define SPMD_PSEL_JOG 4'h5
`define SPMD_PSEL_DI 4'h6
`define SPMD_PSEL_DO 4'h7
`define SPMD_PSEL_MASK 4'h8
`define SPMD_PSEL_NONE 4'hf

// ==========================================================
// digit character codes (0..15 are hex digits)
`define SPMD_CH_BLANK 5'h10
`define SPMD_CH_H 5'h11
`define SPMD_CH_L 5'h12
`define SPMD_CH_J 5'h13
`define SPMD_CH_O 5'h14
`define SPMD_CH_G 5'h15
`define SPMD_BCD_STEPS 6'h20

`endif

//--- rtl/spmd_panel.sv
// front-panel monitor, display formatter, jog, output forcing, diagnosis
// assumes synchronous inputs, level keys, register port master
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "spmd_defines.svh"

module spmd_panel import spmd_pkg::*; #(
  parameter int NVAR = 32,
  parameter int NDO = 3,
  parameter logic [15:0] JOG_MAX = 16'h1388
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // keypad levels
  input wire logic keyUp,
  input wire logic keyDown,
  input wire logic keySet,
  input wire logic keyShift,
  input wire logic keyFmt,
  // parameter-mode context
  input wire logic [3:0] paramSel,
  input wire logic editActive,
  input wire logic [31:0] editValue,
  input wire logic editIs32,
  input wire logic editHex,
  // drive variables
  input wire logic [NVAR-1:0][31:0] varIn,
  input wire logic [7:0] resFirst,
  input wire logic [7:0] resSecond,
  input wire logic [15:0] inertiaTenths,
  input wire logic zIdxFwd,
  input wire logic zIdxRev,
  input wire logic zHome,
  input wire logic [4:0][15:0] faultLog,
  // servo state and digital i/o
  input wire logic servoOn,
  input wire logic [4:0] diIn,
  input wire logic [NDO-1:0] doNormal,
  output logic [NDO-1:0] doOut,
  // jog
  output logic jogFwd,
  output logic jogRev,
  output logic [15:0] jogSpeed,
  // display
  output spmd_disp_t disp
);

  localparam int VW = $clog2(NVAR);

  // ==========================================================
  // parameter check
  if (NVAR < 27 || NVAR > 256 || NDO < 1 || NDO > 16) begin : g_chk
    $error("spmd_panel: NVAR or NDO out of range");
  end

  // ==========================================================
  // reset release
  logic [1:0] rstPipe;
  logic rstSync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rstPipe <= 2'b00;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync = rstPipe[1];

  // ==========================================================
  // registers
  logic [4:0] monSel_reg;
  logic [15:0] specFn_reg;
  logic [15:0] fmask_reg;
  logic [2:0][VW-1:0] mapTgt_reg;
  logic [3:0][VW-1:0] mvCode_reg;
  logic [15:0] jogSpd_reg;
  logic forceEn_reg;
  logic [4:0] monCode_reg;
  logic hiLo_reg;
  logic hexSel_reg;
  spmd_state_t state_reg;
  logic [2:0] faultIdx_reg;
  logic [31:0] zPos_reg;
  logic [4:0] keyPrev_reg;
  logic [31:0] rdata_reg;
  spmd_disp_t disp_reg;
  logic [NDO-1:0] doOut_reg;

  wire wrMonSel = regWr && regAddr == `SPMD_A_MONSEL;
  wire wrSpecFn = regWr && regAddr == `SPMD_A_SPECFN;
  wire wrFmask = regWr && regAddr == `SPMD_A_FMASK;
  wire wrJog = regWr && regAddr == `SPMD_A_JOGSPD;
  wire wrMap = regWr && regAddr >= `SPMD_A_MAPT1
    && regAddr <= `SPMD_A_MAPT3;
  wire wrMvc = regWr && regAddr >= `SPMD_A_MVC1
    && regAddr <= `SPMD_A_MVC4;
  wire [1:0] mapWIdx = 2'(regAddr - `SPMD_A_MAPT1);
  wire [1:0] mvcWIdx = 2'(regAddr - `SPMD_A_MVC1);
  wire codeOk = regWdata[31:5] == 27'h0
    && regWdata[4:0] <= `SPMD_CODE_MAX;

  // ==========================================================
  // key edges and panel state
  wire [4:0] keyNow = {keyFmt, keyShift, keySet, keyDown, keyUp};
  wire [4:0] press = keyNow & ~keyPrev_reg;
  wire pUp = press[0];
  wire pDown = press[1];
  wire pSet = press[2];
  wire pShift = press[3];
  wire pFmt = press[4];
  wire inMonView = state_reg == PS_MONITOR && !editActive
    && paramSel == `SPMD_PSEL_NONE;

  spmd_state_t state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PS_MONITOR: begin
        if (pSet && paramSel <= `SPMD_PSEL_FLAST) state_next = PS_FAULT;
        else if (pSet && paramSel == `SPMD_PSEL_JOG) state_next = PS_JOGSPD;
      end
      PS_FAULT: begin
        if (pSet) state_next = PS_MONITOR;
      end
      PS_JOGSPD: begin
        if (pSet) state_next = PS_JOGRUN;
      end
      PS_JOGRUN: begin
        if (pSet) state_next = PS_MONITOR;
      end
      default: state_next = PS_MONITOR;
    endcase
  end

  // motion follows held keys directly so release stops at once
  assign jogFwd = state_reg == PS_JOGRUN && servoOn && keyUp && !keyDown;
  assign jogRev = state_reg == PS_JOGRUN && servoOn && keyDown && !keyUp;

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      state_reg <= PS_MONITOR;
      keyPrev_reg <= 5'h00;
      faultIdx_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      keyPrev_reg <= keyNow;
      if (state_reg == PS_MONITOR && pSet) faultIdx_reg <= paramSel[2:0];
    end
  end

  // ==========================================================
  // jog speed, monitor code, format toggles
  wire [15:0] jogSpd_next =
    wrJog ? regWdata[15:0] :
    (state_reg == PS_JOGSPD && pUp && jogSpd_reg < JOG_MAX) ?
      jogSpd_reg + 16'h0001 :
    (state_reg == PS_JOGSPD && pDown && jogSpd_reg != 16'h0000) ?
      jogSpd_reg - 16'h0001 : jogSpd_reg;
  wire [4:0] monUp = monCode_reg == `SPMD_CODE_MAX ? 5'h00
    : monCode_reg + 5'h01;
  wire [4:0] monDn = monCode_reg == 5'h00 ? `SPMD_CODE_MAX
    : monCode_reg - 5'h01;
  wire [4:0] monCode_next = (wrMonSel && codeOk) ? regWdata[4:0] :
    (inMonView && pUp) ? monUp : (inMonView && pDown) ? monDn :
    monCode_reg;

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      jogSpd_reg <= `SPMD_JOG_RST;
      monSel_reg <= `SPMD_MONSEL_RST;
      monCode_reg <= `SPMD_MONSEL_RST;
      hiLo_reg <= 1'b1;
      hexSel_reg <= 1'b0;
    end else begin
      jogSpd_reg <= jogSpd_next;
      monCode_reg <= monCode_next;
      if (wrMonSel && codeOk) monSel_reg <= regWdata[4:0];
      if (pShift && (inMonView || editActive)) hiLo_reg <= !hiLo_reg;
      if (pFmt && inMonView) hexSel_reg <= !hexSel_reg;
    end
  end
  assign jogSpeed = jogSpd_reg;

  // ==========================================================
  // selectors, special function, forced outputs
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      specFn_reg <= `SPMD_FN_NORMAL;
      fmask_reg <= 16'h0000;
      mapTgt_reg <= '0;
      mvCode_reg <= '0;
      forceEn_reg <= 1'b0;
    end else begin
      if (wrSpecFn) specFn_reg <= regWdata[15:0];
      if (wrSpecFn && regWdata[15:0] == `SPMD_FN_FORCE) forceEn_reg <= 1'b1;
      if (wrSpecFn && regWdata[15:0] == `SPMD_FN_NORMAL) forceEn_reg <= 1'b0;
      if (wrFmask) fmask_reg <= regWdata[15:0];
      if (wrMap) mapTgt_reg[mapWIdx] <= regWdata[VW-1:0];
      if (wrMvc) mvCode_reg[mvcWIdx] <= regWdata[VW-1:0];
    end
  end

  // upper mask bits never reach doOut; only the mask view and the register read show them
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) doOut_reg <= '0;
    else doOut_reg <= forceEn_reg ? fmask_reg[NDO-1:0] : doNormal;
  end
  assign doOut = doOut_reg;

  // ==========================================================
  // index-relative encoder count
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) zPos_reg <= 32'h00000000;
    else if (zHome) zPos_reg <= 32'h00000000;
    else if (zIdxFwd && !zIdxRev) zPos_reg <= zPos_reg + `SPMD_Z_STEP;
    else if (zIdxRev && !zIdxFwd) zPos_reg <= zPos_reg - `SPMD_Z_STEP;
  end

  // ==========================================================
  // monitor source selection
  wire [1:0] mapIdx = 2'(monCode_reg - `SPMD_CODE_MAP1);
  wire [1:0] mvIdx = 2'(monCode_reg - `SPMD_CODE_MV1);
  wire isMap = monCode_reg >= `SPMD_CODE_MAP1
    && monCode_reg <= `SPMD_CODE_MAP3;
  wire isMv = monCode_reg >= `SPMD_CODE_MV1;
  wire isInertia = monCode_reg == `SPMD_CODE_INERTIA;
  wire isReson = monCode_reg == `SPMD_CODE_RESON;
  wire [31:0] monRaw =
    isReson ? {16'h0000, resSecond, resFirst} :
    (monCode_reg == `SPMD_CODE_ZABS) ? zPos_reg :
    isInertia ? {16'h0000, inertiaTenths} :
    isMap ? varIn[mapTgt_reg[mapIdx]] :
    isMv ? varIn[mvCode_reg[mvIdx]] :
    varIn[VW'(monCode_reg)];
  wire spmd_fmt_t fmtMon = '{val: monRaw, is32: !(isInertia || isReson),
    hex: isReson || (!isInertia && hexSel_reg), sgn: !isReson,
    dp1: isInertia};

  // ==========================================================
  // view selection
  wire spmd_fmt_t fmtJog = '{val: {16'h0000, jogSpd_reg}, is32: 1'b0,
    hex: 1'b0, sgn: 1'b0, dp1: 1'b0};
  wire spmd_fmt_t fmtFault = '{val: {16'h0000, faultLog[faultIdx_reg]},
    is32: 1'b0, hex: 1'b1, sgn: 1'b0, dp1: 1'b0};
  wire spmd_fmt_t fmtEdit = '{val: editValue, is32: editIs32,
    hex: editHex, sgn: 1'b1, dp1: 1'b0};
  wire spmd_fmt_t fmtDi = '{val: {27'h0, diIn}, is32: 1'b0,
    hex: 1'b1, sgn: 1'b0, dp1: 1'b0};
  wire spmd_fmt_t fmtDo = '{val: 32'(doOut_reg), is32: 1'b0,
    hex: 1'b1, sgn: 1'b0, dp1: 1'b0};
  wire spmd_fmt_t fmtMask = '{val: {16'h0000, fmask_reg}, is32: 1'b0,
    hex: 1'b1, sgn: 1'b0, dp1: 1'b0};
  wire inMon = state_reg == PS_MONITOR;
  wire spmd_fmt_t fmt =
    (state_reg == PS_JOGSPD) ? fmtJog :
    (state_reg == PS_FAULT) ? fmtFault :
    editActive ? fmtEdit :
    (paramSel == `SPMD_PSEL_DI) ? fmtDi :
    (paramSel == `SPMD_PSEL_DO) ? fmtDo :
    (paramSel == `SPMD_PSEL_MASK) ? fmtMask : fmtMon;
  wire blankView = inMon && !editActive && paramSel != `SPMD_PSEL_NONE
    && paramSel != `SPMD_PSEL_DI && paramSel != `SPMD_PSEL_DO
    && paramSel != `SPMD_PSEL_MASK;

  // ==========================================================
  // sign and magnitude
  wire [31:0] ext = fmt.is32 ? fmt.val :
    fmt.sgn ? {{16{fmt.val[15]}}, fmt.val[15:0]} :
    {16'h0000, fmt.val[15:0]};
  wire neg = fmt.sgn && !fmt.hex && ext[31];
  wire [31:0] mag = neg ? 32'(~ext + 32'h00000001) : ext;

  // ==========================================================
  // binary to decimal, one bit per cycle, restarts continuously
  function automatic logic [39:0] dabble(input logic [39:0] b,
                                         input logic inBit);
    logic [39:0] a;
    a = b;
    for (int i = 0; i < 10; i++) begin
      if (a[4*i +: 4] > 4'h4) a[4*i +: 4] = a[4*i +: 4] + 4'h3;
    end
    return {a[38:0], inBit};
  endfunction : dabble

  logic [5:0] bcdCnt_reg;
  logic [39:0] bcdAcc_reg;
  logic [31:0] bcdMag_reg;
  logic [39:0] bcd_reg;
  wire [39:0] bcdStep = dabble(bcdAcc_reg, bcdMag_reg[31]);

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      bcdCnt_reg <= 6'h00;
      bcdAcc_reg <= 40'h0;
      bcdMag_reg <= 32'h0;
      bcd_reg <= 40'h0;
    end else if (bcdCnt_reg == 6'h00) begin
      bcdCnt_reg <= `SPMD_BCD_STEPS;
      bcdAcc_reg <= 40'h0;
      bcdMag_reg <= mag;
    end else begin
      bcdCnt_reg <= bcdCnt_reg - 6'h01;
      bcdAcc_reg <= bcdStep;
      bcdMag_reg <= {bcdMag_reg[30:0], 1'b0};
      if (bcdCnt_reg == 6'h01) bcd_reg <= bcdStep;
    end
  end

  // ==========================================================
  // digit formatting
  function automatic logic [3:0][4:0] nib4(input logic [15:0] v);
    return {{1'b0, v[15:12]}, {1'b0, v[11:8]},
            {1'b0, v[7:4]}, {1'b0, v[3:0]}};
  endfunction : nib4

  wire [19:0] decSel = (fmt.is32 && hiLo_reg) ? bcd_reg[39:20]
    : bcd_reg[19:0];
  wire [4:0][4:0] decCode = {{1'b0, decSel[19:16]}, nib4(decSel[15:0])};
  wire [4:0][4:0] hexCode =
    !fmt.is32 ? {`SPMD_CH_BLANK, nib4(ext[15:0])} :
    hiLo_reg ? {`SPMD_CH_H, nib4(ext[31:16])} :
    {`SPMD_CH_L, nib4(ext[15:0])};
  wire [4:0] numDp = {neg, neg, 1'b0, fmt.dp1,
    fmt.is32 && hiLo_reg && !fmt.hex};
  wire spmd_disp_t dispNum = '{code: fmt.hex ? hexCode : decCode,
    dp: numDp};
  wire spmd_disp_t dispJog = '{code: {`SPMD_CH_BLANK, `SPMD_CH_BLANK,
    `SPMD_CH_J, `SPMD_CH_O, `SPMD_CH_G}, dp: 5'h00};
  wire spmd_disp_t dispBlank = '{code: {5{`SPMD_CH_BLANK}}, dp: 5'h00};
  wire spmd_disp_t disp_next = (state_reg == PS_JOGRUN) ? dispJog :
    blankView ? dispBlank : dispNum;

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) disp_reg <= '{code: {5{`SPMD_CH_BLANK}}, dp: 5'h00};
    else disp_reg <= disp_next;
  end
  assign disp = disp_reg;

  // ==========================================================
  // register read port
  wire [31:0] statusWord = {16'h0000, 3'b000, state_reg, forceEn_reg,
    hiLo_reg, hexSel_reg, 3'b000, monCode_reg};
  wire [31:0] rdSel =
    (regAddr == `SPMD_A_MONSEL) ? {27'h0, monSel_reg} :
    (regAddr == `SPMD_A_SPECFN) ? {16'h0000, specFn_reg} :
    (regAddr == `SPMD_A_FMASK) ? {16'h0000, fmask_reg} :
    wrMap || (regAddr >= `SPMD_A_MAPT1 && regAddr <= `SPMD_A_MAPT3) ?
      32'(mapTgt_reg[mapWIdx]) :
    (regAddr >= `SPMD_A_MVC1 && regAddr <= `SPMD_A_MVC4) ?
      32'(mvCode_reg[mvcWIdx]) :
    (regAddr == `SPMD_A_JOGSPD) ? {16'h0000, jogSpd_reg} :
    (regAddr == `SPMD_A_STATUS) ? statusWord :
    (regAddr == `SPMD_A_DISP) ? {2'b00, disp_reg} : 32'h00000000;

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) rdata_reg <= 32'h00000000;
    else rdata_reg <= regRd ? rdSel : 32'h00000000;
  end
  assign regRdata = rdata_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync);

  sequence jogSetPress;
    state_reg == PS_JOGSPD && pSet;
  endsequence
  sequence jogEntered;
    state_reg == PS_JOGRUN ##1 disp.code[0] == `SPMD_CH_G;
  endsequence

  chk_force_enter: assert property (wrSpecFn
    && regWdata[15:0] == `SPMD_FN_FORCE |=> forceEn_reg ##1
    doOut == $past(fmask_reg[NDO-1:0])) else $error("forcing not entered");
  chk_force_leave: assert property (wrSpecFn
    && regWdata[15:0] == `SPMD_FN_NORMAL |=> !forceEn_reg ##1
    doOut == $past(doNormal)) else $error("forcing not left");
  chk_force_mask: assert property (forceEn_reg
    |=> doOut == $past(fmask_reg[NDO-1:0]))
    else $error("forced outputs differ from mask");
  chk_jog_servo: assert property (!servoOn |-> !jogFwd && !jogRev)
    else $error("jog motion without servo on");
  chk_jog_release: assert property (state_reg == PS_JOGRUN
    && !keyUp |-> !jogFwd) else $error("jog did not stop on release");
  chk_jog_entry: assert property (jogSetPress |=> jogEntered)
    else $error("jog mode not entered");
  chk_hex_blank: assert property (!blankView && state_reg != PS_JOGRUN
    && fmt.hex && !fmt.is32 |=> disp.code[4] == `SPMD_CH_BLANK)
    else $error("hex leftmost digit not blank");
  chk_dec_sign: assert property (!blankView && state_reg != PS_JOGRUN
    |=> disp.dp[4] == $past(neg) && disp.dp[3] == $past(neg))
    else $error("sign points wrong");
  chk_z_step: assert property (!zHome && zIdxFwd && !zIdxRev
    |=> zPos_reg == $past(zPos_reg) + `SPMD_Z_STEP)
    else $error("index step not 5000");
  chk_power_mon: assert property ($rose(rstSync) |->
    monCode_reg == monSel_reg && jogSpd_reg == `SPMD_JOG_RST)
    else $error("power-up monitor or jog speed wrong");

endmodule : spmd_panel
`default_nettype wire

//--- rtl/spmd_pkg.sv
// types shared by the panel monitor design
// assumes nothing beyond a SystemVerilog compiler
package spmd_pkg;

  typedef enum logic [1:0] {
    PS_MONITOR = 2'b00,
    PS_FAULT = 2'b01,
    PS_JOGSPD = 2'b10,
    PS_JOGRUN = 2'b11
  } spmd_state_t;

  // five digit codes, code[4] leftmost, and their decimal points
  typedef struct packed {
    logic [4:0][4:0] code;
    logic [4:0] dp;
  } spmd_disp_t;

  // value to format and how
  typedef struct packed {
    logic [31:0] val;
    logic is32;
    logic hex;
    logic sgn;
    logic dp1;
  } spmd_fmt_t;

endpackage : spmd_pkg

//--- verification/spmd_operator.sv
// operator model: presses and holds panel keys
// assumes keys are sampled on rising clk edges
`timescale 1ns/10ps
`default_nettype none

module spmd_operator (
  // clock
  input wire logic clk,
  // keys: up, down, set, shift, format
  output logic [4:0] keys
);
  initial keys = 5'h00;

  // ==========================================================
  // key actions
  task press(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (2) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : press

  task hold(input int k, input logic v);
    @(posedge clk);
    keys[k] <= v;
  endtask : hold
endmodule : spmd_operator
`default_nettype wire

//--- verification/spmd_panel_tb_top.sv
// self-checking bench of the panel monitor
// assumes spmd_operator drives the keypad
`timescale 1ns/10ps
`default_nettype none
`include "spmd_defines.svh"

module spmd_panel_tb_top import spmd_pkg::*;;
  logic clk, rst_n, regWr, regRd, editActive, editIs32, editHex, servoOn;
  logic [7:0] regAddr, resFirst, resSecond;
  logic [31:0] regWdata, regRdata, editValue, rd, val, nv;
  logic [3:0] paramSel;
  logic [31:0][31:0] varIn;
  logic [15:0] inertiaTenths, jogSpeed, mask;
  logic [4:0][15:0] faultLog;
  logic [4:0] diIn, keys;
  logic [2:0] doNormal, doOut, zEv;
  logic jogFwd, jogRev;
  spmd_disp_t disp;
  int errCount, nChecks, cycles, j;

  spmd_operator i_op (.clk(clk), .keys(keys));
  spmd_panel i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .keyUp(keys[0]), .keyDown(keys[1]),
    .keySet(keys[2]), .keyShift(keys[3]), .keyFmt(keys[4]),
    .paramSel(paramSel), .editActive(editActive), .editValue(editValue),
    .editIs32(editIs32), .editHex(editHex), .varIn(varIn),
    .resFirst(resFirst), .resSecond(resSecond),
    .inertiaTenths(inertiaTenths), .zIdxFwd(zEv[0]), .zIdxRev(zEv[1]),
    .zHome(zEv[2]), .faultLog(faultLog), .servoOn(servoOn), .diIn(diIn),
    .doNormal(doNormal), .doOut(doOut), .jogFwd(jogFwd), .jogRev(jogRev),
    .jogSpeed(jogSpeed), .disp(disp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task dchk(input string nm, input spmd_disp_t e);
    @(negedge clk);
    chk(nm, 32'(disp), 32'(e));
    @(posedge clk);
  endtask : dchk

  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task rdReg(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rd = regRdata;
  endtask : rdReg

  task pulse(input int k);
    @(posedge clk);
    zEv[k] <= 1'b1;
    @(posedge clk);
    zEv[k] <= 1'b0;
  endtask : pulse

  task endT(input string nm);
    $display("test %s done", nm);
  endtask : endT

  function automatic spmd_disp_t hx(logic [4:0] p, logic [15:0] v);
    spmd_disp_t d;
    d.dp = 5'h00;
    d.code[4] = p;
    for (int i = 0; i < 4; i++) d.code[i] = {1'b0, v[4*i+:4]};
    return d;
  endfunction : hx

  function automatic spmd_disp_t dc(logic [31:0] m, logic [4:0] p);
    spmd_disp_t d;
    d.dp = p;
    for (int i = 0; i < 5; i++) begin
      d.code[i] = 5'(m % 10);
      m = m / 10;
    end
    return d;
  endfunction : dc

  // expected view of a setting: radix from h, width from w, high half shown
  function automatic spmd_disp_t ed(logic [31:0] v, logic w, logic h);
    logic [31:0] s;
    logic n;
    s = w ? v : 32'(signed'(v[15:0]));
    n = s[31];
    if (h && w) return hx(`SPMD_CH_H, v[31:16]);
    if (h) return hx(`SPMD_CH_BLANK, v[15:0]);
    if (n) s = -s;
    return dc(w ? s / 100000 : s, {n, n, 2'b00, w});
  endfunction : ed

  task complete_run;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      complete_run;
    end
  end

  // ==========================================================
  // tests
  initial begin
    rd = $urandom(32'he04603e1);
    {regWr, regRd, editActive, editIs32, editHex, rst_n} = '0;
    {zEv, regAddr, regWdata} = '0;
    servoOn = 1'b1;
    paramSel = 4'hf;
    editValue = $urandom;
    for (int i = 0; i < 32; i++) varIn[i] = $urandom;
    for (int i = 0; i < 5; i++) faultLog[i] = 16'($urandom);
    {resFirst, resSecond} = 16'($urandom);
    inertiaTenths = 16'($urandom_range(0, 9999));
    diIn = 5'($urandom);
    doNormal = 3'($urandom);
    wt(3);
    rst_n <= 1'b1;
    wt(3);
    rdReg(`SPMD_A_STATUS);
    chk("code", 32'(rd[4:0]), 32'd0);
    rdReg(`SPMD_A_JOGSPD);
    chk("jogReset", rd, 32'd20);
    rdReg(8'h20);
    chk("unmapped", rd, 32'd0);
    endT("reset");
    wr(`SPMD_A_MONSEL, 32'd15);
    wt(70);
    dchk("inertia", dc(32'(inertiaTenths), 5'h02));
    wr(`SPMD_A_MONSEL, 32'd17);
    wt(3);
    dchk("reson", hx(`SPMD_CH_BLANK, {resSecond, resFirst}));
    editActive <= 1'b1;
    editHex <= 1'($urandom);
    editIs32 <= 1'($urandom);
    wt(70);
    dchk("edit", ed(editValue, editIs32, editHex));
    editActive <= 1'b0;
    endT("format16");
    val = $urandom_range(1, 1999999999);
    nv = -val;
    j = $urandom_range(0, 31);
    varIn[j] <= nv;
    wr(`SPMD_A_MVC1, 32'(j));
    wr(`SPMD_A_MONSEL, 32'd23);
    wt(70);
    dchk("negHi", dc(val / 100000, 5'h19));
    i_op.press(3);
    wt(40);
    dchk("negLo", dc(val % 100000, 5'h18));
    i_op.press(4);
    wt(3);
    dchk("hexLo", hx(`SPMD_CH_L, nv[15:0]));
    i_op.press(3);
    wt(3);
    dchk("hexHi", hx(`SPMD_CH_H, nv[31:16]));
    for (int k = 0; k < 3; k++) begin
      j = $urandom_range(0, 31);
      wr(8'(`SPMD_A_MAPT1 + k), 32'(j));
      wr(`SPMD_A_MONSEL, 32'(19 + k));
      wt(3);
      dchk("map", hx(`SPMD_CH_H, varIn[j][31:16]));
    end
    wr(`SPMD_A_MONSEL, 32'd18);
    i_op.press(3);
    for (int k = 0; k < 4; k++) begin
      pulse(k < 2 ? 0 : k - 1);
      wt(3);
      dchk("zcount", hx(`SPMD_CH_L, k == 1 ? 16'h2710 : k == 3 ? 16'h0 :
        16'h1388));
    end
    endT("format32");
    paramSel <= 4'h5;
    i_op.press(2);
    rdReg(`SPMD_A_STATUS);
    chk("jogState", 32'(rd[12:11]), 32'd2);
    i_op.press(0);
    i_op.press(0);
    chk("jogSpeed", 32'(jogSpeed), 32'd22);
    i_op.press(2);
    wt(2);
    dchk("jogInd", {`SPMD_CH_BLANK, `SPMD_CH_BLANK, `SPMD_CH_J, `SPMD_CH_O,
      `SPMD_CH_G, 5'h00});
    i_op.hold(0, 1'b1);
    @(negedge clk);
    chk("fwd", {jogFwd, jogRev}, 32'd2);
    @(posedge clk);
    servoOn <= 1'b0;
    @(negedge clk);
    chk("servoOff", {jogFwd, jogRev}, 32'd0);
    @(posedge clk);
    servoOn <= 1'b1;
    i_op.hold(0, 1'b0);
    i_op.hold(1, 1'b1);
    @(negedge clk);
    chk("rev", {jogFwd, jogRev}, 32'd1);
    i_op.hold(1, 1'b0);
    @(negedge clk);
    chk("stop", {jogFwd, jogRev}, 32'd0);
    i_op.press(2);
    endT("jog");
    for (int k = 0; k < 5; k++) begin
      paramSel <= 4'(k);
      i_op.press(2);
      wt(2);
      dchk("fault", hx(`SPMD_CH_BLANK, faultLog[k]));
      i_op.press(2);
    end
    paramSel <= 4'h6;
    diIn <= 5'($urandom);
    wt(3);
    dchk("di", hx(`SPMD_CH_BLANK, 16'(diIn)));
    paramSel <= 4'h7;
    doNormal <= 3'($urandom);
    wt(4);
    dchk("do", hx(`SPMD_CH_BLANK, 16'(doNormal)));
    endT("diag");
    for (int k = 0; k < 3; k++) begin
      mask = k == 0 ? 16'h2 : k == 1 ? 16'h5 : 16'($urandom);
      wr(`SPMD_A_FMASK, 32'(mask));
      wr(`SPMD_A_SPECFN, 32'(`SPMD_FN_FORCE));
      wt(3);
      @(negedge clk);
      chk("forced", 32'(doOut), 32'(mask[2:0]));
    end
    @(posedge clk);
    paramSel <= 4'h8;
    wt(3);
    dchk("maskView", hx(`SPMD_CH_BLANK, mask));
    wr(`SPMD_A_SPECFN, 32'(`SPMD_FN_NORMAL));
    wt(3);
    @(negedge clk);
    chk("normal", 32'(doOut), 32'(doNormal));
    endT("force");
    complete_run;
  end
endmodule : spmd_panel_tb_top
`default_nettype wire
